// File: rtl/pps_pkg.sv
// Purpose: shared constants and types for the port power sequencer
// Assumes: 200 MHz logic clock
// Notes: register indices are printed offsets; byte address is offset
package pps_pkg;

	localparam int PPS_NPORT = 4;
	localparam int PPS_CLK_MHZ = 200;

	// --------------------------------------------------------------
	// register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] PPS_A_EVT_RO = 8'h04; // class/det events
	localparam logic [7:0] PPS_A_EVT_COR = 8'h05; // same, clear-on-read
	localparam logic [7:0] PPS_A_FLT_RO = 8'h08; // fault events
	localparam logic [7:0] PPS_A_FLT_COR = 8'h09; // same, clear-on-read
	localparam logic [7:0] PPS_A_PWR_EVT = 8'h06; // power-change events
	localparam logic [7:0] PPS_A_STAT0 = 8'h0c; // port status, 0c..0f
	localparam logic [7:0] PPS_A_PWR_STAT = 8'h10; // powered / good
	localparam logic [7:0] PPS_A_CFG = 8'h13; // ac disconnect enable
	localparam logic [7:0] PPS_A_TIM = 8'h16; // fault period, duty
	localparam logic [7:0] PPS_A_PWR_CMD = 8'h19; // on[3:0] off[7:4]
	localparam logic [7:0] PPS_A_RST = 8'h1a; // port/device reset
	localparam logic [7:0] PPS_A_GATE = 8'h23; // gate charge current
	localparam logic [7:0] PPS_A_ILIM = 8'h27; // current limit set
	localparam logic [7:0] PPS_A_TFLT = 8'h28; // fault period fine
	localparam logic [7:0] PPS_A_RSTR = 8'h2a; // auto-restart enable

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int PPS_F_CLASS_LO = 4;
	localparam int PPS_F_CLDONE_LO = 4;
	localparam int PPS_F_SWRST = 4;
	localparam int PPS_F_TFLT_LO = 2;
	localparam int PPS_F_DUTY_LO = 6;
	localparam int PPS_F_HI_NIB = 4;
	localparam int PPS_F_GATE_LO = 5;
	localparam int PPS_F_IVC_LO = 4;
	localparam logic [7:0] PPS_RST_TIM = 8'h00;
	localparam logic [7:0] PPS_RST_REG = 8'h00;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int PPS_GUARD_US_X10 = 5; // 0.5 ms, in tenths of ms
	localparam int PPS_GUARD_CYC = PPS_GUARD_US_X10 * 100 * PPS_CLK_MHZ;
	localparam int PPS_POWER_GOOD_US = 1000;
	localparam int PPS_POWER_GOOD_CYC = PPS_POWER_GOOD_US * PPS_CLK_MHZ;
	localparam int PPS_START_US = 60000;
	localparam int PPS_START_CYC = PPS_START_US * PPS_CLK_MHZ;
	localparam int PPS_FLT_TICK_CYC = 200; // one fault-counter step
	localparam int PPS_DISC_US = 300000;
	localparam int PPS_DISC_CYC = PPS_DISC_US * PPS_CLK_MHZ;

	// class current in 0.25 mA steps from the front end
	localparam logic [7:0] PPS_C1_MIN = 8'h20; // 8 mA
	localparam logic [7:0] PPS_C2_MIN = 8'h40; // 16 mA
	localparam logic [7:0] PPS_C3_MIN = 8'h64; // 25 mA
	localparam logic [7:0] PPS_C4_MIN = 8'h8c; // 35 mA
	localparam logic [7:0] PPS_C4_MAX = 8'hb4; // 45 mA

	typedef enum logic [2:0] {
		PPS_IDLE = 3'b000,
		PPS_WAIT = 3'b001,
		PPS_START = 3'b011,
		PPS_PWR = 3'b010,
		PPS_OFFQ = 3'b110
	} pps_state_t;

	typedef struct packed {
		logic class_done; // pulse, end of classification
		logic [7:0] class_ma4; // measured class current
		logic output_ok; // output within range
		logic in_limit; // current limiter active
		logic over_fault; // sense above fault threshold
		logic over_class; // current above class maximum
	} pps_sense_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pps_bus_t;

endpackage

// File: rtl/pps_sequencer.sv
// Purpose: per-port power sequencing and fault logic, four ports
// Assumes: analogue front ends deliver synchronous sense levels
// Notes: one port turns on and one turns off at a time, lowest index first, except emergency turn-offs
//
// Summary of operation
// - classification end sets class-done flag [7:4] and class field [6:4].
// - class-done clears on read through 05h or on port reset.
// - powering down clears class-done flag and class status.
// - class code from current bands; gaps map to class 0.
// - turn-on grant (entering start-up) resets start-up and disconnect timers.
// - power only when no port turning on and fault counter zero.
// - with ac disconnect enabled, oscillator failure blocks power.
// - power-good after output-ok outlasts delay; clears at once.
// - power-change event on up or down; powered bit follows.
// - 0.5 ms guard after shutdown blocks other turn-offs, except emergency.
// - simultaneous requests serialised, lowest port first, except emergency turn-offs.
// - power-off command bit removes port power.
// - limiter still active at start-up expiry: off and start-up fault.
// - fault counter counts up over threshold, down slower below.
// - counter at limit powers off and sets overcurrent fault.
// - fault period from 16h[3:2] and 28h[7:4].
// - current limit setting from 27h[7:4].
// - after overcurrent off with restart, counter drains before re-power.
// - current above class maximum sets class-overcurrent flag in 09h.
// - gate charge current setting from 23h[7:5].
// - port reset bit in 1Ah[3:0] powers off and clears its registers.
// - 1Ah[4] resets the whole device, an emergency shutdown.
`timescale 1ns/10ps

module pps_sequencer
	import pps_pkg::*;
#(
	parameter int START_CYC = PPS_START_CYC,
	parameter int POWER_GOOD_CYC = PPS_POWER_GOOD_CYC,
	parameter int DISC_CYC = PPS_DISC_CYC
) (
	input wire logic clk, // 200 MHz logic clock
	input wire logic resetn, // synchronous reset, low active
	input wire pps_pkg::pps_bus_t bus, // register port request
	output logic [7:0] rdata, // read data, cycle after strobe
	input wire pps_pkg::pps_sense_t [3:0] sense, // per-port front end
	input wire logic oscillator_failure, // ac oscillator bad
	input wire logic main_supply_lockout, // main supply low
	input wire logic logic_supply_lockout, // logic supply low
	input wire logic thermal_shutdown, // die over temperature
	output logic [3:0] gate_on, // power switch enable per port
	output logic [3:0] power_good, // qualified output good
	output logic [3:0] ilim_set, // current limit setting
	output logic [2:0] gate_current // gate charge setting
);
	import pps_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] class_code(input logic [7:0] i);
		if (i >= PPS_C4_MIN && i <= PPS_C4_MAX) return 3'h4;
		if (i >= PPS_C3_MIN && i <= PPS_C4_MIN - 8'h10) return 3'h3;
		if (i >= PPS_C2_MIN && i <= PPS_C3_MIN - 8'h10) return 3'h2;
		if (i >= PPS_C1_MIN && i <= PPS_C2_MIN - 8'h0c) return 3'h1;
		return 3'h0;
	endfunction

	// strobe-qualified address decode, shared by every clear-on-read flag
	function automatic logic hit(input logic [7:0] a, input logic b);
		return b && bus.addr == a;
	endfunction

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] acd_r, tim_r, gate_r, ilim_r, tflt_r, rstr_r;
	logic emerg;
	logic soft_rst;
	logic [3:0] port_rst;
	logic [3:0] off_cmd;
	logic [3:0] on_cmd;

	assign soft_rst = bus.wr && bus.addr == PPS_A_RST &&
		bus.wdata[PPS_F_SWRST];
	assign port_rst = (bus.wr && bus.addr == PPS_A_RST) ?
		bus.wdata[3:0] : 4'h0;
	assign off_cmd = (bus.wr && bus.addr == PPS_A_PWR_CMD) ?
		bus.wdata[7:4] : 4'h0;
	assign on_cmd = (bus.wr && bus.addr == PPS_A_PWR_CMD) ?
		bus.wdata[3:0] : 4'h0;
	// emergency sources skip the turn-off guard
	assign emerg = !resetn || soft_rst || main_supply_lockout ||
		logic_supply_lockout || thermal_shutdown;

	always_ff @(posedge clk) begin
		if (!resetn || soft_rst) begin
			acd_r <= PPS_RST_REG;
			tim_r <= PPS_RST_TIM;
			gate_r <= PPS_RST_REG;
			ilim_r <= PPS_RST_REG;
			tflt_r <= PPS_RST_REG;
			rstr_r <= PPS_RST_REG;
		end else if (bus.wr) begin
			case (bus.addr)
				PPS_A_CFG: acd_r <= bus.wdata;
				PPS_A_TIM: tim_r <= bus.wdata;
				PPS_A_GATE: gate_r <= bus.wdata;
				PPS_A_ILIM: ilim_r <= bus.wdata;
				PPS_A_TFLT: tflt_r <= bus.wdata;
				PPS_A_RSTR: rstr_r <= bus.wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			ilim_set <= 4'h0;
			gate_current <= 3'h0;
		end else begin
			ilim_set <= ilim_r[PPS_F_HI_NIB +: 4];
			gate_current <= gate_r[PPS_F_GATE_LO +: 3];
		end
	end

	// fault limit: coarse field times 16 plus fine field plus one, never zero
	logic [7:0] flt_lim;
	assign flt_lim = {2'h0, tim_r[PPS_F_TFLT_LO +: 2], 4'h0} +
		{4'h0, tflt_r[PPS_F_HI_NIB +: 4]} + 8'h01;
	// duty field picks the tick phase of each down step; the drain rate is unchanged
	logic [1:0] duty;
	assign duty = tim_r[PPS_F_DUTY_LO +: 2];

	// ------------------------------------------------------------
	// shared sequencing
	// ------------------------------------------------------------
	pps_state_t st_r [4];
	logic [3:0] want_on, want_off;
	logic [3:0] grant_on, grant_off;
	logic any_starting;
	logic [16:0] guard_r;
	logic [3:0] powered_r, pchg_r, cdone_r, sfault_r, ofault_r, ivc_r;
	logic [2:0] class_r [4];

	always_comb begin
		any_starting = 1'b0;
		for (int p = 0; p < PPS_NPORT; p++)
			if (st_r[p] == PPS_START) any_starting = 1'b1;
	end

	// fixed priority, lowest port wins
	always_comb begin
		grant_on = 4'h0;
		grant_off = 4'h0;
		for (int p = PPS_NPORT - 1; p >= 0; p--) begin
			if (want_on[p] && !any_starting) grant_on = 4'h1 << p;
			if (want_off[p] && (guard_r == 17'h0 || emerg))
				grant_off = 4'h1 << p;
		end
		if (emerg) grant_off = want_off;
	end

	always_ff @(posedge clk) begin
		if (!resetn || soft_rst)
			guard_r <= 17'h0;
		else if (grant_off != 4'h0)
			guard_r <= 17'(PPS_GUARD_CYC);
		else if (guard_r != 17'h0)
			guard_r <= guard_r - 17'h1;
	end

	// ------------------------------------------------------------
	// per-port logic
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < PPS_NPORT; g++) begin : g_port
			logic [31:0] tmr_r, pg_r, disc_r;
			logic [7:0] fcnt_r, tick_r;
			logic drain_r;
			logic stop;

			assign stop = port_rst[g] || off_cmd[g] || emerg ||
				(acd_r[g] && oscillator_failure);
			// a stopping port is never granted, else the gate would rise
			// while the state machine drops back to idle
			assign want_on[g] = st_r[g] == PPS_WAIT &&
				fcnt_r == 8'h0 && !stop;
			assign want_off[g] = st_r[g] == PPS_OFFQ;

			always_ff @(posedge clk) begin
				if (!resetn || soft_rst) begin
					st_r[g] <= PPS_IDLE;
					tmr_r <= 32'h0;
					disc_r <= 32'h0;
				end else begin
					case (st_r[g])
						PPS_IDLE:
							if (on_cmd[g]) st_r[g] <= PPS_WAIT;
						PPS_WAIT:
							if (stop) st_r[g] <= PPS_IDLE;
							else if (grant_on[g]) begin
								st_r[g] <= PPS_START;
								tmr_r <= 32'h0;
								disc_r <= 32'h0;
							end
						PPS_START: begin
							tmr_r <= tmr_r + 32'h1;
							if (stop || (tmr_r >= 32'(START_CYC) &&
								sense[g].in_limit))
								st_r[g] <= PPS_OFFQ;
							else if (tmr_r >= 32'(START_CYC))
								st_r[g] <= PPS_PWR;
						end
						PPS_PWR: begin
							if (disc_r < 32'(DISC_CYC))
								disc_r <= disc_r + 32'h1;
							if (stop || fcnt_r >= flt_lim)
								st_r[g] <= PPS_OFFQ;
						end
						PPS_OFFQ:
							if (grant_off[g]) st_r[g] <= PPS_IDLE;
						default: st_r[g] <= PPS_IDLE;
					endcase
				end
			end

			// gate drives from start-up until the turn-off grant
			always_ff @(posedge clk) begin
				if (!resetn || soft_rst)
					gate_on[g] <= 1'b0;
				else if (grant_on[g])
					gate_on[g] <= 1'b1;
				else if (grant_off[g])
					gate_on[g] <= 1'b0;
			end

			// overcurrent counter, up fast, down one step per tick
			always_ff @(posedge clk) begin
				if (!resetn || soft_rst) begin
					fcnt_r <= 8'h0;
					tick_r <= 8'h0;
					drain_r <= 1'b0;
				end else begin
					tick_r <= (tick_r >= 8'(PPS_FLT_TICK_CYC)) ?
						8'h0 : tick_r + 8'h1;
					if (st_r[g] == PPS_PWR && fcnt_r >= flt_lim)
						drain_r <= rstr_r[g];
					if (st_r[g] == PPS_PWR && sense[g].over_fault) begin
						if (fcnt_r < flt_lim)
							fcnt_r <= fcnt_r + 8'h1;
					end else if (st_r[g] == PPS_PWR || drain_r) begin
						if (tick_r == {duty, 6'h0} && fcnt_r != 8'h0)
							fcnt_r <= fcnt_r - 8'h1;
					end else if (port_rst[g] || !rstr_r[g])
						fcnt_r <= 8'h0;
					if (fcnt_r == 8'h0) drain_r <= 1'b0;
				end
			end

			// power-good qualification
			always_ff @(posedge clk) begin
				if (!resetn || soft_rst || !sense[g].output_ok ||
					!gate_on[g]) begin
					pg_r <= 32'h0;
					power_good[g] <= 1'b0;
				end else if (pg_r > 32'(POWER_GOOD_CYC))
					power_good[g] <= 1'b1;
				else
					pg_r <= pg_r + 32'h1;
			end

			// events and status
			always_ff @(posedge clk) begin
				if (!resetn || soft_rst || port_rst[g]) begin
					cdone_r[g] <= 1'b0;
					class_r[g] <= 3'h0;
					pchg_r[g] <= 1'b0;
					powered_r[g] <= 1'b0;
					sfault_r[g] <= 1'b0;
					ofault_r[g] <= 1'b0;
					ivc_r[g] <= 1'b0;
				end else begin
					if (sense[g].class_done) begin
						cdone_r[g] <= 1'b1;
						class_r[g] <= class_code(sense[g].class_ma4);
					end else if (grant_off[g]) begin
						cdone_r[g] <= 1'b0;
						class_r[g] <= 3'h0;
					end else if (hit(PPS_A_EVT_COR, bus.rd))
						cdone_r[g] <= 1'b0;
					if (grant_on[g] || grant_off[g])
						pchg_r[g] <= 1'b1;
					else if (hit(PPS_A_PWR_EVT, bus.rd))
						pchg_r[g] <= 1'b0;
					if (grant_on[g]) powered_r[g] <= 1'b1;
					else if (grant_off[g]) powered_r[g] <= 1'b0;
					if (st_r[g] == PPS_START && tmr_r >= 32'(START_CYC) &&
						sense[g].in_limit)
						sfault_r[g] <= 1'b1;
					else if (hit(PPS_A_FLT_COR, bus.rd))
						sfault_r[g] <= 1'b0;
					if (st_r[g] == PPS_PWR && fcnt_r >= flt_lim)
						ofault_r[g] <= 1'b1;
					else if (hit(PPS_A_FLT_COR, bus.rd))
						ofault_r[g] <= 1'b0;
					if (powered_r[g] && sense[g].over_class)
						ivc_r[g] <= 1'b1;
					else if (hit(PPS_A_FLT_COR, bus.rd))
						ivc_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn)
			rdata <= 8'h0;
		else if (!bus.rd)
			rdata <= 8'h0;
		else begin
			case (bus.addr)
				PPS_A_EVT_RO, PPS_A_EVT_COR:
					rdata <= {cdone_r, 4'h0};
				PPS_A_FLT_RO, PPS_A_FLT_COR:
					rdata <= {ivc_r, ofault_r | sfault_r};
				PPS_A_PWR_EVT: rdata <= {4'h0, pchg_r};
				PPS_A_STAT0: rdata <= {1'b0, class_r[0], 4'h0};
				PPS_A_STAT0 + 8'h1: rdata <= {1'b0, class_r[1], 4'h0};
				PPS_A_STAT0 + 8'h2: rdata <= {1'b0, class_r[2], 4'h0};
				PPS_A_STAT0 + 8'h3: rdata <= {1'b0, class_r[3], 4'h0};
				PPS_A_PWR_STAT: rdata <= {power_good, powered_r};
				PPS_A_CFG: rdata <= acd_r;
				PPS_A_TIM: rdata <= tim_r;
				PPS_A_GATE: rdata <= gate_r;
				PPS_A_ILIM: rdata <= ilim_r;
				PPS_A_TFLT: rdata <= tflt_r;
				PPS_A_RSTR: rdata <= rstr_r;
				default: rdata <= 8'h0;
			endcase
		end
	end

endmodule // pps_sequencer

// File: verif/pps_checker.sv
// Purpose: port-level checks for the port power sequencer
// Assumes: one clock domain, synchronous low-active reset
// Notes: emergency and port resets exempt the turn-off check
`timescale 1ns/10ps
module pps_checker
	import pps_pkg::*;
#(
	parameter int POWER_GOOD_CYC = PPS_POWER_GOOD_CYC
) (
	input wire logic clk, // logic clock
	input wire logic resetn, // sync reset, low active
	input wire pps_pkg::pps_bus_t bus, // register port
	input wire logic [7:0] rdata, // read data
	input wire pps_pkg::pps_sense_t [3:0] sense, // front ends
	input wire logic oscillator_failure, // oscillator bad
	input wire logic main_supply_lockout, // main supply low
	input wire logic logic_supply_lockout, // logic supply low
	input wire logic thermal_shutdown, // over temperature
	input wire logic [3:0] gate_on, // switch enables
	input wire logic [3:0] power_good, // qualified good
	input wire logic [3:0] ilim_set, // limit setting
	input wire logic [2:0] gate_current // gate charge
);
	logic emg;
	logic [3:0] ok_v;
	logic [3:0] il_r;
	logic [2:0] gc_r;
	logic [3:0] pr_r;
	int ok0_r;
	assign emg = main_supply_lockout | logic_supply_lockout |
		thermal_shutdown | (bus.wr && bus.addr == PPS_A_RST);
	assign ok_v = {sense[3].output_ok, sense[2].output_ok,
		sense[1].output_ok, sense[0].output_ok};
	// counts sampled edges with port 0 output ok held high
	always_ff @(posedge clk) begin
		ok0_r <= (!resetn || !sense[0].output_ok) ? 0 : ok0_r + 1;
	end
	always_ff @(posedge clk) begin
		if (bus.wr && bus.addr == PPS_A_ILIM) il_r <= bus.wdata[7:4];
		if (bus.wr && bus.addr == PPS_A_GATE) gc_r <= bus.wdata[7:5];
		if (bus.wr && bus.addr == PPS_A_RST) pr_r <= bus.wdata[3:0];
	end
	// ----
	// assertions
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_single_turn_on: assert property (
		$onehot0(gate_on & ~$past(gate_on)))
		else $error("two ports turned on together");
	a_single_turn_off: assert property (
		!$past(emg) && !$past(emg, 2) |->
		$onehot0($past(gate_on) & ~gate_on))
		else $error("two ports turned off together");
	a_power_good_clear: assert property (
		(power_good & ~$past(ok_v)) == 4'h0)
		else $error("power good kept after output ok fell");
	a_power_good_wait: assert property ($rose(power_good[0]) |->
		ok0_r >= POWER_GOOD_CYC - 1)
		else $error("power good set too early");
	a_lockout_off: assert property (main_supply_lockout ||
		logic_supply_lockout || thermal_shutdown |->
		##[1:2] gate_on == 4'h0)
		else $error("port powered during emergency");
	a_soft_reset: assert property (
		bus.wr && bus.addr == PPS_A_RST && bus.wdata[PPS_F_SWRST] |->
		##[1:2] (gate_on == 4'h0 && ilim_set == 4'h0))
		else $error("device reset left state");
	a_port_reset: assert property (
		bus.wr && bus.addr == PPS_A_RST |->
		##2 (gate_on & pr_r) == 4'h0)
		else $error("port reset left port powered");
	a_ilim_copy: assert property (
		bus.wr && bus.addr == PPS_A_ILIM |-> ##2 ilim_set == il_r)
		else $error("limit setting not taken");
	a_gate_copy: assert property (bus.wr && bus.addr == PPS_A_GATE |->
		##2 gate_current == gc_r)
		else $error("gate charge setting not taken");
endmodule // pps_checker

bind pps_sequencer pps_checker #(.POWER_GOOD_CYC(POWER_GOOD_CYC)) u_chk (.clk(clk),
	.resetn(resetn), .bus(bus), .rdata(rdata), .sense(sense),
	.oscillator_failure(oscillator_failure),
	.main_supply_lockout(main_supply_lockout),
	.logic_supply_lockout(logic_supply_lockout),
	.thermal_shutdown(thermal_shutdown), .gate_on(gate_on),
	.power_good(power_good), .ilim_set(ilim_set),
	.gate_current(gate_current));

// File: verif/pps_pd_model.sv
// Purpose: behavioural powered device and front end, four ports
// Assumes: bench clock
// Notes: class current toggles outside a classification pulse
`timescale 1ns/10ps
module pps_pd_model
	import pps_pkg::*;
(
	input wire logic clk, // logic clock
	input wire logic [3:0] gate_on, // switch enables
	input wire logic [3:0] cls_go, // classify request
	input wire logic [3:0][7:0] cls_ma, // class current
	input wire logic [3:0] stuck, // load keeps limiter on
	input wire logic [3:0] ovl, // draw above fault threshold
	input wire logic [3:0] ovc, // draw above class maximum
	output pps_pkg::pps_sense_t [3:0] sense // front end levels
);
	int cnt [4] = '{0, 0, 0, 0};
	initial sense = '0;
	always @(posedge clk) begin
		for (int p = 0; p < 4; p++) begin
			cnt[p] <= gate_on[p] ? cnt[p] + 1 : 0;
			sense[p].class_done <= cls_go[p];
			// stale value is never held, so a late sample shows up
			sense[p].class_ma4 <= cls_go[p] ? cls_ma[p] : ~sense[p].class_ma4;
			sense[p].output_ok <= gate_on[p] && cnt[p] > 3;
			sense[p].in_limit <= gate_on[p] && (stuck[p] || cnt[p] < 2);
			sense[p].over_fault <= gate_on[p] && ovl[p];
			sense[p].over_class <= gate_on[p] && ovc[p];
		end
	end
endmodule // pps_pd_model

// File: verif/pps_sequencer_tb_top.sv
// Purpose: self-checking bench for the port power sequencer
// Assumes: short start and power-good counts
// Notes: soft resets between tests clear the shutdown guard
`timescale 1ns/10ps
module pps_sequencer_tb_top;
	import pps_pkg::*;
	localparam int ST = 50;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	pps_bus_t bus = '0;
	logic [7:0] rdata;
	pps_sense_t [3:0] sense;
	logic osc = 1'b0;
	logic [2:0] lk = 3'h0;
	logic [3:0] gate_on, power_good, ilim_set, cls_go, stuck, ovl, ovc;
	logic [2:0] gate_current;
	logic [3:0][7:0] cls_ma;
	logic [3:0] prv;
	logic [7:0] v, w;
	int seed = 32212;
	int mismatches = 0;
	int tests_run = 0;
	int cm [4];
	int ord [$];
	always #2.5 clk = ~clk;
	pps_sequencer #(.START_CYC(ST), .POWER_GOOD_CYC(20), .DISC_CYC(50)) DUT (
		.clk(clk), .resetn(resetn), .bus(bus), .rdata(rdata), .sense(sense),
		.oscillator_failure(osc), .main_supply_lockout(lk[0]),
		.logic_supply_lockout(lk[1]), .thermal_shutdown(lk[2]),
		.gate_on(gate_on), .power_good(power_good), .ilim_set(ilim_set),
		.gate_current(gate_current));
	pps_pd_model u_pd (.clk(clk), .gate_on(gate_on), .cls_go(cls_go),
		.cls_ma(cls_ma), .stuck(stuck), .ovl(ovl), .ovc(ovc), .sense(sense));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge clk);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1 chk(rdata & m, e);
	endtask
	task automatic wg(input int p, input logic lv, input int n);
		for (int i = 0; i < n && gate_on[p] !== lv; i++) begin
			@(posedge clk);
			#1;
		end
		chk(8'(gate_on[p]), 8'(lv));
	endtask
	// band table in quarter milliamps; gaps read as class 0
	function automatic logic [7:0] cls(input int m);
		if (m >= 32 && m <= 52) return 8'h10;
		if (m >= 64 && m <= 84) return 8'h20;
		if (m >= 100 && m <= 124) return 8'h30;
		if (m >= 140 && m <= 180) return 8'h40;
		return 8'h00;
	endfunction
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#500000;
		mismatches++;
		close_out;
	end
	initial begin
		cls_go = 4'h0; cls_ma = '0; stuck = 4'h0; ovl = 4'h0; ovc = 4'h0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			for (int p = 0; p < 4; p++) begin
				cm[p] = $unsigned($random(seed)) % 200;
				cls_ma[p] <= 8'(cm[p]);
			end
			cls_go <= 4'hf;
			@(posedge clk);
			cls_go <= 4'h0;
			repeat (2) @(posedge clk);
			for (int p = 0; p < 4; p++)
				rc(PPS_A_STAT0 + 8'(p), 8'h70, cls(cm[p]));
			if (r < 3) begin
				rc(PPS_A_EVT_COR, 8'hf0, 8'hf0);
				rc(PPS_A_EVT_RO, 8'hf0, 8'h00);
			end
		end
		rc(8'h3f, 8'hff, 8'h00);
		$display("done: classes");
		wr(PPS_A_PWR_CMD, 8'h0f);
		prv = 4'h0;
		for (int i = 0; i < 1000 && gate_on !== 4'hf; i++) begin
			@(posedge clk);
			#1;
			for (int p = 0; p < 4; p++) if (gate_on[p] && !prv[p]) ord.push_back(p);
			prv = gate_on;
		end
		chk(8'(ord.size()), 8'h04);
		for (int p = 0; p < 4; p++) chk(8'(ord[p]), 8'(p));
		repeat (100) @(posedge clk);
		rc(PPS_A_PWR_STAT, 8'hff, 8'hff);
		rc(PPS_A_PWR_EVT, 8'h0f, 8'h0f);
		wr(PPS_A_PWR_CMD, 8'h30);
		wg(0, 1'b0, 100);
		repeat (300) @(posedge clk);
		#1 chk(8'(gate_on[1]), 8'h01);
		rc(PPS_A_STAT0, 8'h70, 8'h00);
		rc(PPS_A_EVT_RO, 8'h10, 8'h00);
		rc(PPS_A_PWR_STAT, 8'h33, 8'h22);
		rc(PPS_A_PWR_EVT, 8'h01, 8'h01);
		$display("done: power sequence");
		for (int k = 0; k < 3; k++) begin
			wr(PPS_A_PWR_CMD, 8'h01);
			wg(0, 1'b1, 100);
			@(posedge clk);
			lk <= 3'b001 << k;
			repeat (3) @(posedge clk);
			#1 chk({4'h0, gate_on}, 8'h00);
			@(posedge clk);
			lk <= 3'b000;
			repeat (3) @(posedge clk);
		end
		v = 8'($random(seed));
		w = 8'($random(seed));
		wr(PPS_A_ILIM, v);
		wr(PPS_A_GATE, w);
		repeat (2) @(posedge clk);
		#1 chk({4'h0, ilim_set}, {4'h0, v[7:4]});
		chk({5'h0, gate_current}, {5'h0, w[7:5]});
		$display("done: emergency and settings");
		// the last emergency turn-off armed the guard; clear it
		wr(PPS_A_RST, 8'h10);
		stuck <= 4'h4;
		wr(PPS_A_PWR_CMD, 8'h04);
		wg(2, 1'b1, 100);
		repeat (ST - 5) @(posedge clk);
		#1 chk(8'(gate_on[2]), 8'h01);
		wg(2, 1'b0, 20);
		rc(PPS_A_FLT_RO, 8'h04, 8'h04);
		stuck <= 4'h0;
		wr(PPS_A_RST, 8'h10);
		wr(PPS_A_TFLT, 8'h30);
		wr(PPS_A_TIM, 8'h44);
		wr(PPS_A_RSTR, 8'h02);
		ovl <= 4'h2;
		wr(PPS_A_PWR_CMD, 8'h02);
		wg(1, 1'b1, 100);
		wg(1, 1'b0, 20000);
		rc(PPS_A_FLT_RO, 8'h02, 8'h02);
		ovl <= 4'h0;
		wr(PPS_A_PWR_CMD, 8'h02);
		repeat (100) @(posedge clk);
		#1 chk(8'(gate_on[1]), 8'h00);
		wg(1, 1'b1, 30000);
		ovc <= 4'h2;
		repeat (4) @(posedge clk);
		rc(PPS_A_FLT_RO, 8'h20, 8'h20);
		ovc <= 4'h0;
		wr(PPS_A_RST, 8'h10);
		$display("done: faults");
		wr(PPS_A_CFG, 8'h08);
		osc <= 1'b1;
		wr(PPS_A_PWR_CMD, 8'h08);
		repeat (200) @(posedge clk);
		#1 chk(8'(gate_on[3]), 8'h00);
		// a refused request is dropped, so ask again once the oscillator is back
		@(posedge clk);
		osc <= 1'b0;
		wr(PPS_A_PWR_CMD, 8'h08);
		wg(3, 1'b1, 100);
		wr(PPS_A_RST, 8'h08);
		wg(3, 1'b0, 4);
		rc(PPS_A_PWR_STAT, 8'h88, 8'h00);
		wr(PPS_A_ILIM, 8'hf0);
		wr(PPS_A_RST, 8'h10);
		repeat (2) @(posedge clk);
		#1 chk({4'h0, ilim_set}, 8'h00);
		$display("done: resets");
		close_out;
	end
endmodule // pps_sequencer_tb_top
